/* File: core/awsc_ctrl.sv */
//
// Overview of operation
// - Inactivity timeout switches wake rate to sleep rate
// - Count steps 320 ms, 640 ms at 1.56 Hz
// - Detection and FIFO gate events restart timer
// - Enabled, wake-selected detections wake from sleep
// - Detections run at sleep rate while asleep
// - FIFO, sleep and ready events never wake
// - Gated FIFO freezes on sleep irq until flush
// - Auto-sleep disabled: only standby and wake
// - Each wake/sleep transition raises enabled interrupt
// - Sleep field 00 is 50 Hz, 11 1.56
// - Sleep rate overrides every block rate
// - Wake field maps 800 Hz down to 1.56
// - Bit 0 selects standby or active
// - Fast-read skips low-order data bytes
// - Control two bit 2 enables auto-sleep
// - Interrupt control holds gate and wake selects
//
`timescale 1ns/10ps
`include "awsc_params.svh"

module awsc_ctrl #(
  parameter int BASE_CYCLES = `AWSC_BASE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port from the serial interface engine
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Detection and FIFO events
  input wire logic transient_event_in,
  input wire logic orientation_event_in,
  input wire logic tap_event_in,
  input wire logic freefall_motion_event_in,
  input wire logic sample_ready_event_in,
  input wire logic fifo_event_in,
  input wire logic fifo_flush_in,
  input wire logic sleep_irq_clear_in,
  // Rate and mode outputs
  output awsc_pkg::awsc_rate_t sample_rate_out,
  output logic sample_tick_out,
  output logic active_out,
  output logic asleep_out,
  output logic fast_read_out,
  output logic fifo_accept_out,
  output logic sleep_transition_event_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  awsc_pkg::awsc_byte_t count_q, ctrl1_q, ctrl2_q, intctl_q, inten_q;
  awsc_pkg::awsc_state_e state_q;
  logic [16:0] elapsed_q;
  logic [16:0] target;
  logic frozen_q;
  logic sleep_flag_q;
  logic base_tick;
  logic restart_hit, wake_hit, go_sleep, go_wake, auto_sleep_enable, active;
  awsc_pkg::awsc_rate_t wake_rate;
  logic [1:0] sleep_rate;

  // Sleep field onto the common rate code
  function automatic awsc_pkg::awsc_rate_t sleep_map(input logic [1:0] s);
    case (s)
      `AWSC_SRATE_50HZ: sleep_map = `AWSC_RATE_50HZ;
      `AWSC_SRATE_12HZ: sleep_map = `AWSC_RATE_12HZ;
      `AWSC_SRATE_6HZ: sleep_map = `AWSC_RATE_6HZ;
      default: sleep_map = `AWSC_RATE_1HZ;
    endcase
  endfunction : sleep_map

  assign wake_rate = ctrl1_q[`AWSC_C1_WAKE_HI:`AWSC_C1_WAKE_LO];
  assign sleep_rate = ctrl1_q[`AWSC_C1_SLEEP_HI:`AWSC_C1_SLEEP_LO];
  assign active = ctrl1_q[`AWSC_C1_ACTIVE];
  assign auto_sleep_enable = ctrl2_q[`AWSC_C2_SLEEP_EN];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control one fields are taken at any time; keeping to standby is the host's job
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      count_q <= `AWSC_RST_COUNT;
      ctrl1_q <= `AWSC_RST_CTRL1;
      ctrl2_q <= `AWSC_RST_CTRL2;
      intctl_q <= `AWSC_RST_INTCTL;
      inten_q <= `AWSC_RST_INTEN;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `AWSC_ADDR_COUNT: count_q <= reg_wdata_in;
        `AWSC_ADDR_CTRL1: ctrl1_q <= reg_wdata_in & `AWSC_C1_MASK;
        `AWSC_ADDR_CTRL2: ctrl2_q <= reg_wdata_in & `AWSC_C2_MASK;
        `AWSC_ADDR_INTCTL: intctl_q <= reg_wdata_in & `AWSC_IC_MASK;
        `AWSC_ADDR_INTEN: inten_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Read data lands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `AWSC_ADDR_STATUS: reg_rdata_out <= {6'h00, state_q};
        `AWSC_ADDR_COUNT: reg_rdata_out <= count_q;
        `AWSC_ADDR_CTRL1: reg_rdata_out <= ctrl1_q;
        `AWSC_ADDR_CTRL2: reg_rdata_out <= ctrl2_q;
        `AWSC_ADDR_INTCTL: reg_rdata_out <= intctl_q;
        `AWSC_ADDR_INTEN: reg_rdata_out <= inten_q;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  assign restart_hit = transient_event_in || orientation_event_in || tap_event_in
    || freefall_motion_event_in || (fifo_event_in && intctl_q[`AWSC_IC_FIFO_GATE]);

  // Ready, sleep-transition and FIFO events are absent on purpose
  assign wake_hit =
    (transient_event_in && inten_q[`AWSC_IE_TRANS] && intctl_q[`AWSC_IC_WAKE_TRANS])
    || (orientation_event_in && inten_q[`AWSC_IE_ORIENT]
        && intctl_q[`AWSC_IC_WAKE_ORIENT])
    || (tap_event_in && inten_q[`AWSC_IE_TAP] && intctl_q[`AWSC_IC_WAKE_TAP])
    || (freefall_motion_event_in && inten_q[`AWSC_IE_FFMT]
        && intctl_q[`AWSC_IC_WAKE_FFMT]);

  // ----------------------------------------------------------------
  // Inactivity timer
  // ----------------------------------------------------------------
  assign target = (wake_rate == `AWSC_RATE_1HZ)
    ? 17'(count_q * `AWSC_STEP_SLOW_TICKS)
    : 17'(count_q * `AWSC_STEP_TICKS);

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || state_q != awsc_pkg::ST_WAKE || restart_hit)
      elapsed_q <= '0;
    else if (base_tick && elapsed_q < target)
      elapsed_q <= elapsed_q + 17'h00001;
  end

  assign go_sleep = state_q == awsc_pkg::ST_WAKE && auto_sleep_enable && active && !restart_hit
    && elapsed_q >= target;
  // Dropping auto-sleep also leaves sleep, so it must raise the flag too
  assign go_wake = state_q == awsc_pkg::ST_SLEEP && (wake_hit || !auto_sleep_enable);

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      state_q <= awsc_pkg::ST_STANDBY;
    else
    begin
      case (state_q)
        awsc_pkg::ST_STANDBY:
          if (active)
            state_q <= awsc_pkg::ST_WAKE;
        awsc_pkg::ST_WAKE:
          if (!active)
            state_q <= awsc_pkg::ST_STANDBY;
          else if (go_sleep)
            state_q <= awsc_pkg::ST_SLEEP;
        awsc_pkg::ST_SLEEP:
          if (!active)
            state_q <= awsc_pkg::ST_STANDBY;
          else if (go_wake)
            state_q <= awsc_pkg::ST_WAKE;
        default: state_q <= awsc_pkg::ST_STANDBY;
      endcase
    end
  end

  // Sticky sleep-transition flag: a new transition beats the clear
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      sleep_flag_q <= 1'b0;
    else if ((go_sleep || go_wake) && inten_q[`AWSC_IE_SLEEP_IRQ] && active)
      sleep_flag_q <= 1'b1;
    else if (sleep_irq_clear_in)
      sleep_flag_q <= 1'b0;
  end

  // FIFO freeze: flag with gate set holds the old contents until flush
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      frozen_q <= 1'b0;
    else if ((go_sleep || go_wake) && inten_q[`AWSC_IE_SLEEP_IRQ] && active
      && intctl_q[`AWSC_IC_FIFO_GATE])
      frozen_q <= 1'b1;
    else if (fifo_flush_in)
      frozen_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Rate selection and timebase
  // ----------------------------------------------------------------
  // One rate feeds the whole sensor, so detections follow it into sleep
  assign sample_rate_out = (state_q == awsc_pkg::ST_SLEEP)
    ? sleep_map(sleep_rate) : wake_rate;

  awsc_rate_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .run_in(state_q != awsc_pkg::ST_STANDBY),
    .rate_in(sample_rate_out),
    .base_tick_out(base_tick),
    .sample_tick_out(sample_tick_out)
  );

  assign active_out = state_q != awsc_pkg::ST_STANDBY;
  assign asleep_out = state_q == awsc_pkg::ST_SLEEP;
  assign fast_read_out = ctrl1_q[`AWSC_C1_FAST_READ];
  assign fifo_accept_out = !frozen_q;
  assign sleep_transition_event_out = sleep_flag_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_no_sleep_disabled: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!auto_sleep_enable && state_q != awsc_pkg::ST_SLEEP) |=> state_q != awsc_pkg::ST_SLEEP)
    else $error("entered sleep with auto-sleep off");
  a_sleep_rate_used: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state_q == awsc_pkg::ST_SLEEP |-> sample_rate_out == sleep_map(sleep_rate))
    else $error("sleep rate not applied");
  a_wake_rate_used: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state_q == awsc_pkg::ST_WAKE
    |-> sample_rate_out == ctrl1_q[`AWSC_C1_WAKE_HI:`AWSC_C1_WAKE_LO])
    else $error("wake rate not applied");
  a_standby_select: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !ctrl1_q[`AWSC_C1_ACTIVE] |=> !active_out)
    else $error("not in standby with active bit clear");
  a_wake_on_source: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (asleep_out && active && tap_event_in && inten_q[`AWSC_IE_TAP]
      && intctl_q[`AWSC_IC_WAKE_TAP])
    |=> state_q == awsc_pkg::ST_WAKE)
    else $error("selected tap did not wake");
  a_no_stray_wake: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (asleep_out && active && auto_sleep_enable && !wake_hit) |=> asleep_out)
    else $error("woke without a selected source");
  a_irq_on_change: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (inten_q[`AWSC_IE_SLEEP_IRQ] && active && $changed(asleep_out) && $past(active_out)
      && $past(inten_q[`AWSC_IE_SLEEP_IRQ]) && $past(active)) |-> sleep_transition_event_out)
    else $error("transition did not raise flag");
  a_fifo_frozen: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (frozen_q && !fifo_flush_in) |=> !fifo_accept_out)
    else $error("fifo accepted while frozen");
  a_restart_holds: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_q == awsc_pkg::ST_WAKE && active && restart_hit)
    |=> (state_q == awsc_pkg::ST_WAKE && elapsed_q == '0))
    else $error("restart event did not hold wake");
  a_timeout_due: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ($rose(asleep_out) && $past(state_q) == awsc_pkg::ST_WAKE)
    |-> $past(elapsed_q) >= $past(target))
    else $error("sleep entered before timeout");

endmodule : awsc_ctrl

/* File: core/awsc_params.svh */
`ifndef AWSC_PARAMS_SVH
`define AWSC_PARAMS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define AWSC_ADDR_STATUS 8'h0b
`define AWSC_ADDR_COUNT 8'h29
`define AWSC_ADDR_CTRL1 8'h2a
`define AWSC_ADDR_CTRL2 8'h2b
`define AWSC_ADDR_INTCTL 8'h2c
`define AWSC_ADDR_INTEN 8'h2d

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AWSC_RST_COUNT 8'h00
`define AWSC_RST_CTRL1 8'h00
`define AWSC_RST_CTRL2 8'h00
`define AWSC_RST_INTCTL 8'h00
`define AWSC_RST_INTEN 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AWSC_C1_SLEEP_HI 7
`define AWSC_C1_SLEEP_LO 6
`define AWSC_C1_WAKE_HI 5
`define AWSC_C1_WAKE_LO 3
`define AWSC_C1_FAST_READ 1
`define AWSC_C1_ACTIVE 0
`define AWSC_C2_SLEEP_EN 2
`define AWSC_IC_FIFO_GATE 7
`define AWSC_IC_WAKE_TRANS 6
`define AWSC_IC_WAKE_ORIENT 5
`define AWSC_IC_WAKE_TAP 4
`define AWSC_IC_WAKE_FFMT 3
`define AWSC_IE_SLEEP_IRQ 7
`define AWSC_IE_TRANS 5
`define AWSC_IE_ORIENT 4
`define AWSC_IE_TAP 3
`define AWSC_IE_FFMT 2
`define AWSC_C2_MASK 8'h04
`define AWSC_C1_MASK 8'hfb
`define AWSC_IC_MASK 8'hf8

// ----------------------------------------------------------------
// Rate codes and timing
// ----------------------------------------------------------------
`define AWSC_RATE_50HZ 3'h4
`define AWSC_RATE_12HZ 3'h5
`define AWSC_RATE_6HZ 3'h6
`define AWSC_RATE_1HZ 3'h7
`define AWSC_SRATE_50HZ 2'h0
`define AWSC_SRATE_12HZ 2'h1
`define AWSC_SRATE_6HZ 2'h2
`define AWSC_CLK_PERIOD_NS 10
`define AWSC_BASE_PERIOD_NS 1250000
`define AWSC_BASE_CYCLES (`AWSC_BASE_PERIOD_NS / `AWSC_CLK_PERIOD_NS)
`define AWSC_STEP_MS 320
`define AWSC_STEP_SLOW_MS 640
`define AWSC_BASE_PERIOD_US 1250
`define AWSC_STEP_TICKS (`AWSC_STEP_MS * 1000 / `AWSC_BASE_PERIOD_US)
`define AWSC_STEP_SLOW_TICKS (`AWSC_STEP_SLOW_MS * 1000 / `AWSC_BASE_PERIOD_US)
`define AWSC_TICKS_12HZ 10'h040
`define AWSC_TICKS_6HZ 10'h080
`define AWSC_TICKS_1HZ 10'h200
`define AWSC_TICK_ONE 10'h001

`endif

/* File: core/awsc_pkg.sv */
package awsc_pkg;
  typedef enum logic [1:0] {ST_STANDBY, ST_WAKE, ST_SLEEP} awsc_state_e;
  typedef logic [2:0] awsc_rate_t;
  typedef logic [7:0] awsc_byte_t;
endpackage : awsc_pkg

/* File: core/awsc_rate_timer.sv */
`timescale 1ns/10ps
`include "awsc_params.svh"

module awsc_rate_timer #(
  parameter int BASE_CYCLES = `AWSC_BASE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Rate selection
  input wire logic run_in,
  input wire awsc_pkg::awsc_rate_t rate_in,
  // Timebase
  output logic base_tick_out,
  output logic sample_tick_out
);

  logic [16:0] div_q;
  logic [9:0] sub_q;
  logic [9:0] limit;

  // Base ticks per sample period at each rate code
  function automatic logic [9:0] rate_ticks(input awsc_pkg::awsc_rate_t r);
    case (r)
      `AWSC_RATE_12HZ: rate_ticks = `AWSC_TICKS_12HZ;
      `AWSC_RATE_6HZ: rate_ticks = `AWSC_TICKS_6HZ;
      `AWSC_RATE_1HZ: rate_ticks = `AWSC_TICKS_1HZ;
      default: rate_ticks = `AWSC_TICK_ONE << r;
    endcase
  endfunction : rate_ticks

  assign limit = rate_ticks(rate_in);
  assign base_tick_out = run_in && (div_q == 17'(BASE_CYCLES - 1));

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || !run_in || base_tick_out)
      div_q <= '0;
    else
      div_q <= div_q + 17'h00001;
  end

  // Rate change keeps the sample phase; a count already past the new limit ends on the next base tick
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || !run_in)
    begin
      sub_q <= '0;
      sample_tick_out <= 1'b0;
    end
    else
    begin
      sample_tick_out <= 1'b0;
      if (base_tick_out)
      begin
        if (sub_q + 10'h001 >= limit)
        begin
          sub_q <= '0;
          sample_tick_out <= 1'b1;
        end
        else
          sub_q <= sub_q + 10'h001;
      end
    end
  end

endmodule : awsc_rate_timer

/* File: tb/awsc_ctrl_tb_top.sv */
`timescale 1ns/10ps
`include "awsc_params.svh"

module awsc_ctrl_tb_top;
  // ---------------------------------------------------------------
  // Set-up
  // ---------------------------------------------------------------
  // Short base tick keeps each inactivity step near 2560 cycles, 5120 at the 1.56 Hz wake rate
  localparam int BASE = 10;
  localparam int STEP = 256 * BASE;
  localparam int NT[8] = '{1, 2, 4, 8, 16, 64, 128, 512};
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr, reg_wdata, rdata, rv;
  logic reg_wr, reg_rd;
  logic rd_q = 1'b0;
  logic [7:0] ev = 8'h00;
  awsc_pkg::awsc_rate_t rate;
  logic tick, active, asleep, fast, accept, flag;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'h8f171337;
  int n;

  always #5 clk_sys_in = ~clk_sys_in;

  awsc_host_model u_host (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr),
    .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd));

  awsc_ctrl #(.BASE_CYCLES(BASE)) dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
    .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .transient_event_in(ev[0]),
    .orientation_event_in(ev[1]), .tap_event_in(ev[2]), .freefall_motion_event_in(ev[3]),
    .sample_ready_event_in(ev[4]), .fifo_event_in(ev[5]), .fifo_flush_in(ev[6]),
    .sleep_irq_clear_in(ev[7]), .sample_rate_out(rate), .sample_tick_out(tick),
    .active_out(active), .asleep_out(asleep), .fast_read_out(fast),
    .fifo_accept_out(accept), .sleep_transition_event_out(flag));

  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Read data is settled by the falling edge after the strobe was taken
  always @(posedge clk_sys_in) rd_q <= reg_rd;
  always @(negedge clk_sys_in)
    if (rd_q === 1'b1 && u_host.exp_q.size() > 0)
      chk(rdata, u_host.exp_q.pop_front());

  // ---------------------------------------------------------------
  // Stimulus helpers
  // ---------------------------------------------------------------
  task automatic pulse(input int i);
    @(negedge clk_sys_in);
    ev[i] = 1'b1;
    @(negedge clk_sys_in);
    ev[i] = 1'b0;
    @(negedge clk_sys_in);
  endtask : pulse

  task automatic wait_lvl(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (asleep !== lvl)
    begin
      @(negedge clk_sys_in);
      cnt++;
      if (cnt > lim)
      begin
        error_cnt++;
        end_sim();
      end
    end
  endtask : wait_lvl

  // Second count is a full tick-to-tick gap
  task automatic tick_gap(output int cnt);
    for (int j = 0; j < 2; j++)
    begin
      cnt = 0;
      do
      begin
        @(negedge clk_sys_in);
        cnt++;
        if (cnt > 6000)
        begin
          error_cnt++;
          end_sim();
        end
      end while (tick !== 1'b1);
    end
  endtask : tick_gap

  function automatic logic [7:0] near(input int v, input int e);
    return {7'h00, (v >= e - 15) && (v <= e + 15)};
  endfunction : near

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    u_host.rd(8'h29, 8'h00);
    u_host.rd(8'h2a, 8'h00);
    u_host.rd(8'h2b, 8'h00);
    u_host.rd(8'h0b, 8'h00);
    rv = 8'($random(seed));
    u_host.wr(8'h29, rv);
    u_host.rd(8'h29, rv);
    u_host.wr(8'h2b, 8'hff);
    u_host.rd(8'h2b, 8'h04);
    u_host.wr(8'h2c, 8'hff);
    u_host.rd(8'h2c, 8'hf8);
    u_host.wr(8'h30, 8'h5a);
    u_host.rd(8'h30, 8'h00);
    u_host.set_ctrl1(8'hfa);
    u_host.rd(8'h2a, 8'hfa);
    chk({7'h00, fast}, 8'h01);
    chk({7'h00, active}, 8'h00);
    u_host.set_ctrl1(8'h00);
    chk({7'h00, fast}, 8'h00);
    u_host.wr(8'h2d, 8'h88);
    u_host.wr(8'h2c, 8'h90);
    u_host.wr(8'h2b, 8'h04);
    u_host.wr(8'h29, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      u_host.set_ctrl1({s[1:0], 3'h2, 3'h1});
      wait_lvl(1'b1, STEP + 100, n);
      chk(near(n, STEP), 8'h01);
      chk({5'h00, rate}, 8'(4 + s));
      chk({6'h00, flag, accept}, 8'h02);
      u_host.rd(8'h0b, 8'h02);
      tick_gap(n);
      chk(n[7:0], 8'(10 * NT[4 + s]));
      chk(n[15:8], 8'((10 * NT[4 + s]) >> 8));
      pulse(4);
      pulse(5);
      pulse(0);
      chk({7'h00, asleep}, 8'h01);
      pulse(6);
      chk({7'h00, accept}, 8'h01);
      pulse(7);
      chk({7'h00, flag}, 8'h00);
      pulse(2);
      chk({6'h00, asleep, flag}, 8'h01);
      chk({5'h00, rate}, 8'h02);
      pulse(7);
      pulse(6);
    end
    u_host.set_ctrl1(8'h39);
    repeat (3000) @(negedge clk_sys_in);
    chk({7'h00, asleep}, 8'h00);
    pulse(1);
    wait_lvl(1'b1, 2 * STEP + 100, n);
    chk(near(n, 2 * STEP - 2), 8'h01);
    u_host.wr(8'h2b, 8'h00);
    u_host.set_ctrl1(8'h21);
    tick_gap(n);
    chk(n[7:0], 8'(10 * NT[4]));
    chk(n[15:8], 8'((10 * NT[4]) >> 8));
    repeat (3000) @(negedge clk_sys_in);
    chk({7'h00, asleep}, 8'h00);
    u_host.rd(8'h0b, 8'h01);
    // Every wake code with auto-sleep off: rate code and full sample period
    for (int c = 0; c < 8; c++)
    begin
      u_host.set_ctrl1({2'h0, c[2:0], 3'h1});
      chk({5'h00, rate}, 8'(c));
      tick_gap(n);
      chk(n[7:0], 8'(10 * NT[c]));
      chk(n[15:8], 8'((10 * NT[c]) >> 8));
    end
    end_sim();
  end
endmodule : awsc_ctrl_tb_top

/* File: tb/awsc_host_model.sv */
`timescale 1ns/10ps
`include "awsc_params.svh"

module awsc_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Register port towards the block
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out
);
  // ---------------------------------------------------------------
  // Expected read data, oldest first
  // ---------------------------------------------------------------
  logic [7:0] exp_q[$];
  logic [7:0] ctrl1_q;

  initial
  begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
    ctrl1_q = `AWSC_RST_CTRL1;
  end

  // ---------------------------------------------------------------
  // Bus cycles, launched on the falling edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_out = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge clk_sys_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clk_sys_in);
    reg_rd_out = 1'b0;
  endtask : rd

  // Fast-read is only ever changed here, and this host drops to standby before other control one bits change
  task automatic set_ctrl1(input logic [7:0] v);
    if (ctrl1_q[0] && (v[7:1] != ctrl1_q[7:1]))
      wr(`AWSC_ADDR_CTRL1, ctrl1_q & 8'hfe);
    wr(`AWSC_ADDR_CTRL1, v);
    ctrl1_q = v;
  endtask : set_ctrl1
endmodule : awsc_host_model
